/* shared/flow_pulse_pkg.sv */
// Package: register map, unit codes, timing constants and carrier types for the flow pulse output
package flow_pulse_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] OFS_FACTOR_UNIT  = 16'h0025;
  localparam logic [15:0] OFS_WIDTH_MODE   = 16'h0055;
  localparam logic [15:0] OFS_VOLUME_SCALE = 16'h0147;
  localparam logic [15:0] OFS_DURATION     = 16'h0149;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [15:0] RESET_WIDTH_MODE   = 16'h0000;
  localparam logic [31:0] RESET_VOLUME_SCALE = 32'h0000_03e8;
  localparam logic [31:0] RESET_DURATION_US  = 32'h0000_01f4; // 0.5 ms

  ////////////////////////////////////////////////////////////////////////////////
  // Width setting limits in microseconds: 0.1 ms to 650 ms
  localparam logic [31:0] DURATION_MIN_US = 32'h0000_0064;
  localparam logic [31:0] DURATION_MAX_US = 32'h0009_eb10;

  // Mode values
  localparam logic [15:0] MODE_FIXED_WIDTH = 16'h0000;
  localparam logic [15:0] MODE_FREQUENCY   = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  // Unit codes for the factor unit
  localparam logic [7:0] UNIT_GALLONS      = 8'h28; // 40
  localparam logic [7:0] UNIT_LITERS       = 8'h29; // 41
  localparam logic [7:0] UNIT_IMP_GALLONS  = 8'h2a; // 42
  localparam logic [7:0] UNIT_CUBIC_METERS = 8'h2b; // 43
  localparam logic [7:0] UNIT_FEET         = 8'h2c; // 44
  localparam logic [7:0] UNIT_METERS       = 8'h2d; // 45
  localparam logic [7:0] UNIT_BARRELS_42   = 8'h2e; // 46
  localparam logic [7:0] UNIT_KILOGRAMS    = 8'h3d; // 61
  localparam logic [7:0] UNIT_SHORT_TONS   = 8'h40; // 64
  localparam logic [7:0] UNIT_CUBIC_FEET   = 8'h70; // 112
  localparam logic [7:0] UNIT_CUBIC_CM     = 8'hf6; // 246
  localparam logic [7:0] UNIT_BARRELS_31   = 8'hf7; // 247
  localparam logic [7:0] UNIT_MEGA_GALLONS = 8'hf9; // 249
  localparam logic [7:0] UNIT_SPECIAL      = 8'hfd; // 253

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CYCLES_PER_US   = CLK_HZ / 1_000_000;
  localparam int unsigned FULL_SCALE_HZ   = 10_000;
  localparam int unsigned OVER_RANGE_PCT  = 110;
  localparam int unsigned CEILING_HZ      = 11_000;
  localparam int unsigned SAFE_LIMIT_HZ   = 5_000;
  // Least period rounds up to whole cycles
  localparam int unsigned STD_PERIOD_CYC  = (CLK_HZ + CEILING_HZ - 1) / CEILING_HZ;
  localparam int unsigned SAFE_PERIOD_CYC = (CLK_HZ + SAFE_LIMIT_HZ - 1) / SAFE_LIMIT_HZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Register access carrier
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_req_t;

  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_HIGH,
    GEN_LOW
  } gen_state_t;

endpackage

/* verilog/level_sync.sv */
// Two flip-flop synchroniser for a level from outside the clock domain
module level_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* verilog/flow_scaled_pulse_output.sv */
// Flow-proportional pulse output: accumulator, rate limiter, width modes and register file

// What this block does
// - Pulse frequency runs from zero to a 10,000 Hz full scale set by scaling.
// - Over range allowed to 110 percent, never beyond an absolute 11,000 Hz.
// - Intrinsically safe variant caps the pulse rate at 5000 Hz.
// - One pulse is emitted per configured scaling quantity of volume.
// - Any nonzero scaling quantity is accepted, covering the full documented range.
// - Factor unit reads back, read-only, the unit of the configured flow rate.
// - Unit codes: volume, mass 61-64, feet 44, meters 45, special 253.
// - Width settings 0.1 ms to 650 ms accepted; default is 0.5 ms.
// - Output frequency is held down so duty cycle never passes 50 percent.
// - Mode 0 fixed width (default), mode 1 frequency output at 50 percent duty.
// - Width setting applies only in fixed-width mode, ignored in frequency mode.
module flow_scaled_pulse_output #(
  parameter int unsigned FLOW_W          = 32,
  parameter int unsigned STD_PERIOD_CYC  = flow_pulse_pkg::STD_PERIOD_CYC,
  parameter int unsigned SAFE_PERIOD_CYC = flow_pulse_pkg::SAFE_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Measured flow, quantity per clock in scaling units
  input  wire logic [FLOW_W-1:0]        flow_increment,
  input  wire logic [7:0]               flow_unit_code,
  // Hardware variant strap pin
  input  wire logic                     safe_variant,
  // Register access
  input  wire flow_pulse_pkg::reg_req_t reg_req,
  output logic [31:0]                   reg_rdata,
  output logic                          reg_rvalid,
  // Switch closure output
  output logic                          pulse_out
);

  // Refuse parameter values the counters cannot serve
  if (FLOW_W < 8 || FLOW_W > 32) begin : g_bad_flow_w
    $error("FLOW_W must lie in 8..32");
  end
  if (STD_PERIOD_CYC < 2 || SAFE_PERIOD_CYC < STD_PERIOD_CYC) begin : g_bad_period
    $error("bad period limits");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] width_mode;
  logic [31:0] volume_scale;
  logic [31:0] duration_us;
  logic        safe_sync;

  level_sync u_strap_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (safe_variant),
    .sync_out (safe_sync)
  );

  // Address decode and write acceptance
  wire hit_unit     = reg_req.addr == flow_pulse_pkg::OFS_FACTOR_UNIT;
  wire hit_mode     = reg_req.addr == flow_pulse_pkg::OFS_WIDTH_MODE;
  wire hit_scale    = reg_req.addr == flow_pulse_pkg::OFS_VOLUME_SCALE;
  wire hit_duration = reg_req.addr == flow_pulse_pkg::OFS_DURATION;
  wire mode_ok      = reg_req.wdata[15:0] == flow_pulse_pkg::MODE_FIXED_WIDTH ||
                      reg_req.wdata[15:0] == flow_pulse_pkg::MODE_FREQUENCY;
  wire duration_ok  = reg_req.wdata >= flow_pulse_pkg::DURATION_MIN_US &&
                      reg_req.wdata <= flow_pulse_pkg::DURATION_MAX_US;
  wire scale_ok     = reg_req.wdata != 32'h0000_0000;
  wire freq_mode    = width_mode == flow_pulse_pkg::MODE_FREQUENCY;

  // Write enables; a refused value leaves the register as it was
  wire write_mode     = reg_req.write && hit_mode && mode_ok;
  wire write_scale    = reg_req.write && hit_scale && scale_ok;
  wire write_duration = reg_req.write && hit_duration && duration_ok;

  // Factor unit follows the flow unit; unknown codes show as special units
  wire [7:0] c = flow_unit_code;
  // Volume codes
  wire unit_volume = c == flow_pulse_pkg::UNIT_GALLONS || c == flow_pulse_pkg::UNIT_LITERS ||
                     c == flow_pulse_pkg::UNIT_IMP_GALLONS || c == flow_pulse_pkg::UNIT_CUBIC_METERS ||
                     c == flow_pulse_pkg::UNIT_BARRELS_42 || c == flow_pulse_pkg::UNIT_CUBIC_FEET ||
                     c == flow_pulse_pkg::UNIT_CUBIC_CM || c == flow_pulse_pkg::UNIT_BARRELS_31 ||
                     c == flow_pulse_pkg::UNIT_MEGA_GALLONS;
  // Mass codes form one unbroken run
  wire unit_mass   = c >= flow_pulse_pkg::UNIT_KILOGRAMS && c <= flow_pulse_pkg::UNIT_SHORT_TONS;
  // Length codes
  wire unit_length = c == flow_pulse_pkg::UNIT_FEET || c == flow_pulse_pkg::UNIT_METERS;
  wire unit_known  = unit_volume || unit_mass || unit_length;
  wire [7:0] unit_shown = unit_known ? c : flow_pulse_pkg::UNIT_SPECIAL;

  // Narrow registers read back in the low bits
  wire [31:0] unit_word = {24'h00_0000, unit_shown};
  wire [31:0] mode_word = {16'h0000, width_mode};

  // Read data selection
  wire [31:0] next_rdata = hit_unit     ? unit_word :
                           hit_mode     ? mode_word :
                           hit_scale    ? volume_scale :
                           hit_duration ? duration_us : 32'h0000_0000;

  // Register writes; out-of-range values are ignored, unit is read-only
  always_ff @(posedge clk) begin
    if (reset) begin
      width_mode   <= flow_pulse_pkg::RESET_WIDTH_MODE;
      volume_scale <= flow_pulse_pkg::RESET_VOLUME_SCALE;
      duration_us  <= flow_pulse_pkg::RESET_DURATION_US;
    end else begin
      if (write_mode) width_mode <= reg_req.wdata[15:0];
      if (write_scale) volume_scale <= reg_req.wdata;
      if (write_duration) duration_us <= reg_req.wdata;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_req.read ? next_rdata : 32'h0000_0000;
      reg_rvalid <= reg_req.read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flow accumulator and owed pulse count
  logic [39:0] acc;
  logic [15:0] owed;
  logic        take_pulse;

  wire [39:0] sum       = acc + {{(40-FLOW_W){1'b0}}, flow_increment};
  wire        crossing  = sum >= {8'h00, volume_scale};
  wire [39:0] next_acc  = crossing ? sum - {8'h00, volume_scale} : sum;
  wire        owed_full = owed == 16'hffff;

  // One pulse owed per full quantity, remainder kept
  // Owed count saturates so a long burst never wraps to zero
  always_ff @(posedge clk) begin
    if (reset) begin
      acc  <= 40'h00_0000_0000;
      owed <= 16'h0000;
    end else begin
      acc <= next_acc;
      if (crossing && !take_pulse && !owed_full) owed <= owed + 16'h0001;
      else if (!crossing && take_pulse) owed <= owed - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interval between crossings, used for 50 percent duty in frequency mode
  logic [31:0] since_cross;
  logic [31:0] interval;

  // Count saturates; a long stall reads as a very slow rate
  always_ff @(posedge clk) begin
    if (reset) begin
      since_cross <= 32'h0000_0000;
      interval    <= 32'h0000_0000;
    end else if (crossing) begin
      since_cross <= 32'h0000_0001;
      interval    <= since_cross;
    end else if (since_cross != 32'hffff_ffff) begin
      since_cross <= since_cross + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // High and low times
  localparam logic [31:0] STD_PERIOD  = 32'(STD_PERIOD_CYC);
  localparam logic [31:0] SAFE_PERIOD = 32'(SAFE_PERIOD_CYC);
  localparam logic [31:0] CYC_PER_US  = 32'(flow_pulse_pkg::CYCLES_PER_US);

  // Least period from the synchronised variant strap
  wire [31:0] min_period  = safe_sync ? SAFE_PERIOD : STD_PERIOD;
  wire [31:0] min_half    = (min_period + 32'h0000_0001) >> 1;

  // Frequency mode: half the crossing interval, never under half the least period
  wire [31:0] freq_half   = (interval >> 1) > min_half ? interval >> 1 : min_half;

  // Fixed mode: width as set, low stretched so the closed time stays at or under half
  wire [31:0] width_cyc   = 32'(duration_us * CYC_PER_US);
  wire [31:0] fixed_rest  = min_period > width_cyc ? min_period - width_cyc : 32'h0000_0000;
  wire [31:0] fixed_low   = fixed_rest > width_cyc ? fixed_rest : width_cyc;

  // Times handed to the generator by mode
  wire [31:0] high_time   = freq_mode ? freq_half : width_cyc;
  wire [31:0] low_time    = freq_mode ? freq_half : fixed_low;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse generator
  flow_pulse_pkg::gen_state_t state;
  flow_pulse_pkg::gen_state_t next_state;
  logic [31:0] timer;

  // Phase ends on the last count, so a phase of n cycles loads n
  wire timer_done = timer <= 32'h0000_0001;
  // Owed pulse taken only from idle; the idle cycle adds one to each period
  assign take_pulse = state == flow_pulse_pkg::GEN_IDLE && owed != 16'h0000;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      flow_pulse_pkg::GEN_IDLE: if (take_pulse) next_state = flow_pulse_pkg::GEN_HIGH;
      flow_pulse_pkg::GEN_HIGH: if (timer_done) next_state = flow_pulse_pkg::GEN_LOW;
      flow_pulse_pkg::GEN_LOW:  if (timer_done) next_state = flow_pulse_pkg::GEN_IDLE;
      default:                  next_state = flow_pulse_pkg::GEN_IDLE;
    endcase
  end

  // State, timer and output flop
  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= flow_pulse_pkg::GEN_IDLE;
      timer     <= 32'h0000_0000;
      pulse_out <= 1'b0;
    end else begin
      state     <= next_state;
      pulse_out <= next_state == flow_pulse_pkg::GEN_HIGH;
      if (take_pulse) timer <= high_time;
      else if (state == flow_pulse_pkg::GEN_HIGH && timer_done) timer <= low_time;
      else if (!timer_done) timer <= timer - 32'h0000_0001;
    end
  end

endmodule

/* bench/flow_pulse_sva.sv */
// Checker for the flow pulse output ports
module flow_pulse_sva #(
  parameter int unsigned STD_PERIOD_CYC  = 20,
  parameter int unsigned SAFE_PERIOD_CYC = 40
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     reset,
  // Inputs seen
  input wire logic [31:0]              flow_increment,
  input wire logic [7:0]               flow_unit_code,
  input wire logic                     safe_variant,
  input wire flow_pulse_pkg::reg_req_t reg_req,
  // Outputs seen
  input wire logic [31:0]              reg_rdata,
  input wire logic                     reg_rvalid,
  input wire logic                     pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic        prev;
  logic [15:0] gap;
  logic [15:0] pa;
  wire         rise = pulse_out && !prev;
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last closure began, and the address of the last request
  always_ff @(posedge clk) begin
    pa   <= reg_req.addr;
    prev <= reset ? 1'b0 : pulse_out;
    gap  <= reset ? 16'hffff : rise ? 16'h0001 : (gap == 16'hffff) ? gap : gap + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_req.read |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_no_stray: assert property (!reg_req.read |=> !reg_rvalid)
    else $error("answer without read");
  a_idle_zero: assert property (!reg_rvalid |-> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_mode_legal: assert property (reg_rvalid && pa == flow_pulse_pkg::OFS_WIDTH_MODE |-> reg_rdata <= 32'h1)
    else $error("mode outside 0 and 1");
  a_width_legal: assert property (reg_rvalid && pa == flow_pulse_pkg::OFS_DURATION
    |-> reg_rdata inside {[flow_pulse_pkg::DURATION_MIN_US:flow_pulse_pkg::DURATION_MAX_US]})
    else $error("width outside limits");
  a_scale_nonzero: assert property (reg_rvalid && pa == flow_pulse_pkg::OFS_VOLUME_SCALE |-> reg_rdata != 0)
    else $error("scale reads zero");
  a_unit_follow: assert property (reg_rvalid && pa == flow_pulse_pkg::OFS_FACTOR_UNIT
    && $past(flow_unit_code) inside {8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2e, 8'h70, 8'hf6, 8'hf7, 8'hf9,
    [8'h3d:8'h40], 8'h2c, 8'h2d, 8'hfd} |-> reg_rdata == {24'h0, $past(flow_unit_code)})
    else $error("factor unit does not follow flow unit");
  a_pulse_spacing: assert property (rise |-> gap >= (safe_variant ? SAFE_PERIOD_CYC : STD_PERIOD_CYC))
    else $error("closures closer than the least period");
  // Main scenarios reached
  c_pulse: cover property (rise);
  c_read: cover property (reg_rvalid);
  c_safe: cover property (rise && safe_variant);
endmodule

/* bench/pulse_counter.sv */
// Model of the external counter fed by the switch closure
module pulse_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Switch closure in
  input wire logic pulse_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int   falls;
  int   high_len;
  int   hi_cnt;
  int   gap;
  int   gap_cnt;
  logic prev;
  // Counts closures, measures closed time and spacing of closures
  always @(posedge clk) begin
    if (reset) begin
      falls   = 0;
      hi_cnt  = 0;
      gap_cnt = 0;
      prev    = 1'b0;
    end else begin
      gap_cnt++;
      if (pulse_in && !prev) begin
        gap     = gap_cnt;
        gap_cnt = 0;
      end
      if (pulse_in) hi_cnt++;
      else if (prev) begin
        high_len = hi_cnt;
        hi_cnt   = 0;
        falls++;
      end
      prev = pulse_in;
    end
  end
endmodule

/* bench/tb_top.sv */
// Testbench for the flow pulse output
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STD_P = 20;
  localparam int SAFE_P = 40;
  localparam int W_CYC = 100 * flow_pulse_pkg::CYCLES_PER_US;
  logic                     clk;
  logic                     reset;
  logic [31:0]              flow_increment;
  logic [7:0]               flow_unit_code;
  logic                     safe_variant;
  flow_pulse_pkg::reg_req_t reg_req;
  logic [31:0]              reg_rdata;
  logic                     reg_rvalid;
  logic                     pulse_out;
  logic [31:0]              exp_q[$];
  logic [7:0]               codes[16] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2e, 8'h70, 8'hf6, 8'hf7, 8'hf9,
                                          8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h2c, 8'h2d, 8'hfd};
  int                       num_errors = 0;
  int                       check_count = 0;
  int                       cycles = 0;
  int                       seed = 76;
  flow_scaled_pulse_output #(.STD_PERIOD_CYC(STD_P), .SAFE_PERIOD_CYC(SAFE_P)) dut (.clk(clk), .reset(reset),
    .flow_increment(flow_increment), .flow_unit_code(flow_unit_code), .safe_variant(safe_variant),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pulse_out(pulse_out));
  pulse_counter pc (.clk(clk), .reset(reset), .pulse_in(pulse_out));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One bus cycle, strobe held for one clock
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_req = '{addr: a, wdata: d, write: w, read: !w};
    @(negedge clk);
    reg_req = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Flow for cyc clocks (inc below zero: random), then count and time closures
  task automatic flow_run(input string nm, input int cyc, input int inc, input int n, input int hi, input int gp);
    int base;
    int total;
    base  = pc.falls;
    total = 0;
    repeat (cyc) begin
      @(negedge clk);
      flow_increment = (inc < 0) ? $unsigned($random(seed)) % 100 : inc;
      total += flow_increment;
    end
    @(negedge clk);
    flow_increment = '0;
    if (inc < 0) n = total / 1000;
    for (int t = 0; t < 45000 && pc.falls < base + n; t++) @(negedge clk);
    repeat (100) @(negedge clk);
    chk("pulse count", n, pc.falls - base);
    if (hi > 0) chk("closed time", hi, pc.high_len);
    if (hi > 0) chk("pulse spacing", gp, pc.gap);
    $display("Test %s done", nm);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Read answers compared against the oldest note
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) chk("read data", exp_q.pop_front(), reg_rdata);
  end
  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    reset          = 1'b1;
    flow_increment = '0;
    flow_unit_code = 8'h28;
    safe_variant   = 1'b0;
    reg_req        = '0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rd(flow_pulse_pkg::OFS_WIDTH_MODE, 32'h0);
    rd(flow_pulse_pkg::OFS_VOLUME_SCALE, flow_pulse_pkg::RESET_VOLUME_SCALE);
    rd(flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::RESET_DURATION_US);
    rd(16'h0030, 32'h0);
    bus(1'b1, flow_pulse_pkg::OFS_FACTOR_UNIT, 32'h29);
    rd(flow_pulse_pkg::OFS_FACTOR_UNIT, 32'h28);
    bus(1'b1, flow_pulse_pkg::OFS_WIDTH_MODE, 32'h2);
    rd(flow_pulse_pkg::OFS_WIDTH_MODE, 32'h0);
    bus(1'b1, flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::DURATION_MIN_US - 32'h1);
    bus(1'b1, flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::DURATION_MAX_US + 32'h1);
    rd(flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::RESET_DURATION_US);
    bus(1'b1, flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::DURATION_MAX_US);
    rd(flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::DURATION_MAX_US);
    bus(1'b1, flow_pulse_pkg::OFS_VOLUME_SCALE, 32'h0);
    rd(flow_pulse_pkg::OFS_VOLUME_SCALE, flow_pulse_pkg::RESET_VOLUME_SCALE);
    foreach (codes[i]) begin
      flow_unit_code = codes[i];
      rd(flow_pulse_pkg::OFS_FACTOR_UNIT, {24'h0, codes[i]});
    end
    flow_unit_code = 8'h05;
    rd(flow_pulse_pkg::OFS_FACTOR_UNIT, {24'h0, flow_pulse_pkg::UNIT_SPECIAL});
    $display("Test registers done");
    bus(1'b1, flow_pulse_pkg::OFS_VOLUME_SCALE, 32'd100);
    bus(1'b1, flow_pulse_pkg::OFS_WIDTH_MODE, flow_pulse_pkg::MODE_FREQUENCY);
    flow_run("frequency", 30, 100, 30, STD_P / 2, 2 * ((STD_P + 1) / 2) + 1);
    safe_variant = 1'b1;
    flow_run("safe", 10, 100, 10, SAFE_P / 2, 2 * ((SAFE_P + 1) / 2) + 1);
    safe_variant = 1'b0;
    bus(1'b1, flow_pulse_pkg::OFS_DURATION, flow_pulse_pkg::DURATION_MIN_US);
    bus(1'b1, flow_pulse_pkg::OFS_WIDTH_MODE, flow_pulse_pkg::MODE_FIXED_WIDTH);
    flow_run("fixed", 2, 100, 2, W_CYC, 2 * W_CYC + 1);
    bus(1'b1, flow_pulse_pkg::OFS_VOLUME_SCALE, 32'd1000);
    bus(1'b1, flow_pulse_pkg::OFS_WIDTH_MODE, flow_pulse_pkg::MODE_FREQUENCY);
    flow_run("random", 400, -1, 0, 0, 0);
    chk("reads answered", 32'h0, exp_q.size());
    summarize();
  end
endmodule
bind flow_scaled_pulse_output flow_pulse_sva #(.STD_PERIOD_CYC(STD_PERIOD_CYC), .SAFE_PERIOD_CYC(SAFE_PERIOD_CYC))
  u_sva (.clk(clk), .reset(reset), .flow_increment(flow_increment), .flow_unit_code(flow_unit_code),
  .safe_variant(safe_variant), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pulse_out(pulse_out));
